// ==== bus_status_code_bus_master.sv ====
// Purpose: behavioural two-wire master transmitter
// Assumes: pull-ups on both lines, 80 ns bit period
// Notes: clock stands high between frames
`timescale 1ns/100ps
`default_nettype none
module bus_status_code_bus_master (
    output logic scl_m, // master clock, 1 releases
    output logic sda_m, // master data, 1 releases
    input wire logic scl_w, // resolved clock line
    input wire logic sda_w // resolved data line
);
    // ****************
    // bus tasks
    // ****************
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    task automatic bus_start;
        sda_m = 1'b0;
        #40;
        scl_m = 1'b0;
    endtask : bus_start
    task automatic bus_stop;
        // room for the slave to release its ack after the last fall
        #60;
        sda_m = 1'b0;
        #20;
        scl_m = 1'b1;
        #40;
        sda_m = 1'b1;
        #80;
    endtask : bus_stop
    // msb first; extra low time lets the slave release its ack
    task automatic bus_byte(input logic [7:0] b, output logic ack);
        #40;
        for (int i = 7; i >= 0; i--) begin
            #20;
            sda_m = b[i];
            #20;
            scl_m = 1'b1;
            wait (scl_w === 1'b1);
            #40;
            scl_m = 1'b0;
        end
        #20;
        sda_m = 1'b1;
        #100;
        scl_m = 1'b1;
        wait (scl_w === 1'b1);
        #40;
        ack = ~sda_w;
        scl_m = 1'b0;
    endtask : bus_byte
endmodule : bus_status_code_bus_master
`default_nettype wire

// ==== bus_status_code_line_sync.sv ====
// Purpose: synchronise scl and sda and detect bus edges and conditions
// Assumes: scl and sda come from pins outside the clock domain
// Notes: events are one-cycle pulses on clk
`timescale 1ns/100ps
`default_nettype none
module bus_status_code_line_sync
    import bus_status_code_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic reset_n, // synchronous reset, active low
    input wire logic scl_in, // bus clock pin level
    input wire logic sda_in, // bus data pin level
    output var bus_status_code_bus_ev_t bus_ev // decoded bus events
);
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic scl_q;
    logic sda_q;

    // three flops each; the second stage is compared against the third
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scl_meta <= 2'h3;
            sda_meta <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_meta <= {scl_meta[0], scl_in};
            sda_meta <= {sda_meta[0], sda_in};
            scl_q <= scl_meta[1];
            sda_q <= sda_meta[1];
        end
    end

    // start: sda falls while scl high; stop: sda rises while scl high
    always_comb begin
        bus_ev.sda = sda_meta[1];
        bus_ev.scl_rise = scl_meta[1] & ~scl_q;
        bus_ev.scl_fall = ~scl_meta[1] & scl_q;
        bus_ev.start = scl_meta[1] & scl_q & sda_q & ~sda_meta[1];
        bus_ev.stop = scl_meta[1] & scl_q & ~sda_q & sda_meta[1];
    end
endmodule : bus_status_code_line_sync
`default_nettype wire

// ==== bus_status_code_pkg.sv ====
// Purpose: constants and carrier types for the two-wire slave receiver
// Assumes: 100 MHz system clock, bus pins sampled through synchronisers
// Notes: register offsets are local indices on the plain register port
package bus_status_code_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [2:0] ADDR_SLAVE_MATCH = 3'h0;
    localparam logic [2:0] ADDR_CONTROL = 3'h1;
    localparam logic [2:0] ADDR_STATUS = 3'h2;
    localparam logic [2:0] ADDR_DATA = 3'h3;
    localparam logic [2:0] ADDR_SLEEP = 3'h4;
    localparam logic [7:0] SLAVE_MATCH_RESET = 8'h00;

    // ************************************************************
    // control field positions
    // ************************************************************
    localparam int CTL_INT = 7;
    localparam int CTL_ACK = 6;
    localparam int CTL_STA = 5;
    localparam int CTL_STO = 4;
    localparam int CTL_EN = 2;
    localparam int CTL_IE = 0;

    // ************************************************************
    // status codes, prescaler bits always zero
    // ************************************************************
    localparam logic [7:0] ST_OWN_W = 8'h60;
    localparam logic [7:0] ST_ARB_OWN_W = 8'h68;
    localparam logic [7:0] ST_GCALL = 8'h70;
    localparam logic [7:0] ST_ARB_GCALL = 8'h78;
    localparam logic [7:0] ST_DATA_ACK = 8'h80;
    localparam logic [7:0] ST_DATA_NACK = 8'h88;
    localparam logic [7:0] ST_GDATA_ACK = 8'h90;
    localparam logic [7:0] ST_GDATA_NACK = 8'h98;
    localparam logic [7:0] ST_IDLE = 8'hF8;
    localparam logic [7:0] STATUS_CODE_MASK = 8'hF8;
    localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // software control fields written through the control register
    typedef struct packed {
        logic interrupt_enable;
        logic interface_enable;
        logic stop_request;
        logic start_request;
        logic acknowledge_enable;
    } bus_status_code_ctl_t;

    // conditions seen on the synchronised bus lines
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } bus_status_code_bus_ev_t;
endpackage : bus_status_code_pkg

// ==== bus_status_code_slave_rx.sv ====
// Purpose: two-wire slave receiver with software status handshake
// Assumes: external master; registers on a plain one-cycle port
// Notes: clock stretching while the interrupt flag is set
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module bus_status_code_slave_rx
    import bus_status_code_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic reset_n, // synchronous reset, active low
    input wire logic [2:0] reg_addr, // register index
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_write, // write strobe
    input wire logic reg_read, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic scl_in, // bus clock pin
    input wire logic sda_in, // bus data pin
    output logic scl_oe, // drive scl low when high
    output logic sda_oe, // drive sda low when high
    input wire logic arb_lost, // own master lost arbitration, pulse
    input wire logic deep_sleep, // clocks to the interface are off
    output logic wake_req, // wake the part after address match
    output logic irq // interrupt flag gated by enable
);
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_ADDR = 5'b00010,
        S_AACK = 5'b00100,
        S_DATA = 5'b01000,
        S_DACK = 5'b10000
    } bus_status_code_state_t;

    // ************************************************************
    // state and software-visible registers
    // ************************************************************
    bus_status_code_bus_ev_t ev;
    bus_status_code_state_t state;
    bus_status_code_ctl_t ctl;
    logic [7:0] slave_address_match;
    logic interrupt_flag;
    logic [7:0] bus_status_code;
    logic [7:0] bus_data_byte;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic arb_pending;
    logic gcall;
    logic ack_bit;
    logic [7:0] next_status;

    // ************************************************************
    // pin synchroniser
    // ************************************************************
    bus_status_code_line_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .bus_ev(ev)
    );

    // address compare, used for own and general call
    function automatic logic [1:0] addr_hit(input logic [7:0] a,
                                           input logic [7:0] m);
        addr_hit[1] = (a[7:1] == m[7:1]);
        addr_hit[0] = (a[7:1] == GENERAL_CALL_ADDR) & m[0];
    endfunction : addr_hit

    logic [1:0] hit;
    assign hit = addr_hit(shift, slave_address_match);

    // address byte taken: write direction, ack on, own or general call;
    // shared by the state machine and the flag so the two cannot drift
    function automatic logic addr_accept(input logic [1:0] h,
                                         input logic [7:0] a,
                                         input logic ack_en);
        addr_accept = ack_en && !a[0] && (h[1] || h[0]);
    endfunction : addr_accept

    // ************************************************************
    // register writes
    // ************************************************************
    // software setup; start/stop kept as written, unused by receiver
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            slave_address_match <= SLAVE_MATCH_RESET;
            ctl <= '0;
        end else if (reg_write && reg_addr == ADDR_SLAVE_MATCH) begin
            slave_address_match <= reg_wdata;
        end else if (reg_write && reg_addr == ADDR_CONTROL) begin
            ctl.acknowledge_enable <= reg_wdata[CTL_ACK];
            ctl.start_request <= reg_wdata[CTL_STA];
            ctl.stop_request <= reg_wdata[CTL_STO];
            ctl.interface_enable <= reg_wdata[CTL_EN];
            ctl.interrupt_enable <= reg_wdata[CTL_IE];
        end
    end

    // arbitration loss remembered until the ack slot of an accepted address ends
    // a stop leaves it set; only an accepted address consumes it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            arb_pending <= 1'b0;
        end else if (arb_lost) begin
            arb_pending <= 1'b1;
        end else if (state == S_AACK && ev.scl_fall) begin
            arb_pending <= 1'b0;
        end
    end

    // ************************************************************
    // bus state machine
    // ************************************************************
    // bit shifting on scl rising edges, freezes while flag set
    always_ff @(posedge clk) begin
        if (!reset_n || !ctl.interface_enable) begin
            state <= S_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            gcall <= 1'b0;
            ack_bit <= 1'b0;
        end else if (ev.stop) begin
            state <= S_IDLE;
        end else if (ev.start) begin
            state <= S_ADDR;
            bit_cnt <= 4'h0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    bit_cnt <= 4'h0;
                end
                S_ADDR, S_DATA: begin
                    if (ev.scl_rise) begin
                        shift <= {shift[6:0], ev.sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (ev.scl_fall && bit_cnt == BITS_PER_BYTE) begin
                        bit_cnt <= 4'h0;
                        if (state == S_ADDR) begin
                            // no ack while disabled; bus still watched
                            if (addr_accept(hit, shift,
                                            ctl.acknowledge_enable)) begin
                                gcall <= ~hit[1];
                                state <= S_AACK;
                            end else begin
                                state <= S_IDLE;
                            end
                        end else begin
                            ack_bit <= ctl.acknowledge_enable;
                            state <= S_DACK;
                        end
                    end
                end
                S_AACK, S_DACK: begin
                    // leave ack slot on next fall, once flag released
                    if (ev.scl_fall && !interrupt_flag) begin
                        state <= (state == S_DACK && !ack_bit) ?
                                 S_IDLE : S_DATA;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ************************************************************
    // status codes
    // ************************************************************
    // status codes for each completed phase
    always_comb begin
        next_status = bus_status_code;
        if (state == S_ADDR) begin
            if (hit[1]) begin
                next_status = arb_pending ? ST_ARB_OWN_W : ST_OWN_W;
            end else begin
                next_status = arb_pending ? ST_ARB_GCALL : ST_GCALL;
            end
        end else if (state == S_DATA) begin
            if (gcall) begin
                next_status = ctl.acknowledge_enable ? ST_GDATA_ACK :
                              ST_GDATA_NACK;
            end else begin
                next_status = ctl.acknowledge_enable ? ST_DATA_ACK :
                              ST_DATA_NACK;
            end
        end
    end

    // ************************************************************
    // interrupt flag and data
    // ************************************************************
    // a byte is done on the fall that ends its eighth bit
    logic byte_done;
    assign byte_done = ev.scl_fall && bit_cnt == BITS_PER_BYTE &&
                       ((state == S_ADDR &&
                         addr_accept(hit, shift, ctl.acknowledge_enable)) ||
                        state == S_DATA);

    // write of one clears the flag; a set in the same cycle wins so
    // that a byte finishing under a late clear is never lost
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            interrupt_flag <= 1'b0;
            bus_status_code <= ST_IDLE;
            bus_data_byte <= 8'h00;
        end else if (byte_done && ctl.interface_enable) begin
            interrupt_flag <= 1'b1;
            bus_status_code <= next_status & STATUS_CODE_MASK;
            // after a wake the shift is clocked by slow logic; no promise
            if (state == S_DATA) begin
                bus_data_byte <= shift;
            end
        end else if (reg_write && reg_addr == ADDR_CONTROL &&
                     reg_wdata[CTL_INT]) begin
            interrupt_flag <= 1'b0;
            // nothing pending once software has taken the code
            bus_status_code <= ST_IDLE;
        end
    end

    // ************************************************************
    // pin drive and outputs
    // ************************************************************
    // ack drives sda low through the whole ack slot
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= (state == S_AACK) ||
                      (state == S_DACK && ack_bit);
        end
    end

    // flag holds scl low in the ack slot so the master waits for
    // software; a slow wake therefore blocks the whole bus meanwhile
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scl_oe <= 1'b0;
        end else begin
            scl_oe <= interrupt_flag &&
                      (state == S_AACK || state == S_DACK);
        end
    end

    // wake whenever the flag is set while asleep, never on bus noise
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= deep_sleep && interrupt_flag;
        end
    end

    // interrupt line follows the flag when software enabled it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= interrupt_flag && ctl.interrupt_enable;
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    // unmapped indices read zero so probing software sees no junk
    always_ff @(posedge clk) begin
        if (!reset_n || !reg_read) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                ADDR_SLAVE_MATCH: reg_rdata <= slave_address_match;
                ADDR_CONTROL: reg_rdata <= {interrupt_flag,
                    ctl.acknowledge_enable, ctl.start_request,
                    ctl.stop_request, 1'b0, ctl.interface_enable, 1'b0,
                    ctl.interrupt_enable};
                ADDR_STATUS: reg_rdata <= bus_status_code;
                ADDR_DATA: reg_rdata <= bus_data_byte;
                ADDR_SLEEP: reg_rdata <= {7'h00, deep_sleep};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule : bus_status_code_slave_rx
`default_nettype wire

// ==== bus_status_code_slave_rx_sva.sv ====
// Purpose: port checker for the two-wire slave receiver
// Assumes: one clock domain, synchronous active-low reset
// Notes: attached to the design by the bind at the foot
`timescale 1ns/100ps
`default_nettype none
module bus_status_code_slave_rx_chk
    import bus_status_code_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic reset_n, // sync reset
    input wire logic [2:0] reg_addr, // register index
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_write, // write strobe
    input wire logic reg_read, // read strobe
    input wire logic [7:0] reg_rdata, // read data
    input wire logic scl_in, // bus clock level
    input wire logic sda_in, // bus data level
    input wire logic scl_oe, // clock stretch
    input wire logic sda_oe, // ack drive
    input wire logic arb_lost, // lost arbitration
    input wire logic deep_sleep, // sleep level
    input wire logic wake_req, // wake request
    input wire logic irq // flag output
);
    // ****************
    // helpers
    // ****************
    logic ctl_wr;
    // any control write may legally move the flag
    assign ctl_wr = reg_write && reg_addr == ADDR_CONTROL;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_clear;
        ctl_wr && reg_wdata[CTL_INT] && irq;
    endsequence
    sequence s_held;
        irq ##1 irq;
    endsequence
    // irq lags the flag a cycle, so a write one cycle back may drop it
    sequence s_quiet;
        irq && !ctl_wr && !$past(ctl_wr);
    endsequence
    // ****************
    // properties
    // ****************
    a_flag_hold: assert property (s_quiet |=> irq)
        else $error("flag dropped without a control write");
    a_clear_release: assert property (s_clear |-> ##[1:4] !scl_oe)
        else $error("clock still held after flag clear");
    a_flag_stretch: assert property (s_held |-> scl_oe)
        else $error("flag set but clock not held");
    a_irq_stretch: assert property ($rose(irq) |-> ##[0:3] scl_oe)
        else $error("flag rose without clock stretch");
    a_wake_sleep: assert property (wake_req |-> $past(deep_sleep))
        else $error("wake request outside sleep");
    a_wake_hold: assert property ($rose(wake_req) |-> ##[0:2] scl_oe)
        else $error("wake without clock hold");
    a_sda_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line moved while clock high");
    a_ack_held: assert property ($rose(sda_oe) |-> scl_oe)
        else $error("ack driven without stretch");
    a_status_low: assert property (reg_read && reg_addr == ADDR_STATUS
        |=> reg_rdata[2:0] == 3'h0)
        else $error("status low bits not zero");
endmodule : bus_status_code_slave_rx_chk
bind bus_status_code_slave_rx bus_status_code_slave_rx_chk chk_u (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl_in),
    .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .arb_lost(arb_lost), .deep_sleep(deep_sleep), .wake_req(wake_req),
    .irq(irq));
`default_nettype wire

// ==== bus_status_code_slave_rx_test.sv ====
// Purpose: self-checking bench for the slave receiver
// Assumes: master model drives the bus, bench plays software
// Notes: read results checked from a queue of expectations
`timescale 1ns/100ps
`default_nettype none
module bus_status_code_slave_rx_test
    import bus_status_code_pkg::*;
;
    logic clk, reset_n, reg_write, reg_read, arb_lost, deep_sleep;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic scl_oe, sda_oe, wake_req, irq, scl_m, sda_m, scl_w, sda_w;
    logic rd_d, ack;
    logic [6:0] own;
    logic [7:0] exp_q[$];
    int num_errors, checks, cycles;
    // open-drain lines with pull-ups
    assign scl_w = scl_m & ~scl_oe;
    assign sda_w = sda_m & ~sda_oe;
    bus_status_code_slave_rx dut_u (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl_w),
        .sda_in(sda_w), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .arb_lost(arb_lost), .deep_sleep(deep_sleep),
        .wake_req(wake_req), .irq(irq));
    bus_status_code_bus_master mst_u (.scl_m(scl_m), .sda_m(sda_m), .scl_w(scl_w),
        .sda_w(sda_w));
    // ****************
    // clock, watcher, timeout
    // ****************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        rd_d <= reg_read;
        if (rd_d) begin
            check_val("read data", exp_q.pop_front(), reg_rdata);
        end
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            final_report();
        end
    end
    // ****************
    // tasks
    // ****************
    task automatic check_val(input string what, input logic [7:0] e,
        input logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : check_val
    task automatic check_bit(input string what, input logic e,
        input logic g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %b seen %b", what, e, g);
        end
    endtask : check_bit
    function automatic logic [7:0] ctl(input logic a, input logic clr);
        ctl = 8'h00;
        ctl[CTL_INT] = clr;
        ctl[CTL_ACK] = a;
        ctl[CTL_EN] = 1'b1;
        ctl[CTL_IE] = 1'b1;
    endfunction : ctl
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
    endtask : rd
    // software answer to a raised flag
    task automatic serve(input logic [7:0] st, input logic a);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        check_bit("irq", 1'b1, irq);
        check_bit("wake", deep_sleep, wake_req);
        rd(ADDR_STATUS, st);
        wr(ADDR_CONTROL, ctl(a, 1'b1));
    endtask : serve
    task automatic xfer(input logic [7:0] b, input logic ea,
        input logic [7:0] st, input logic a);
        fork
            mst_u.bus_byte(b, ack);
            if (st != ST_IDLE) serve(st, a);
        join
        check_bit("ack", ea, ack);
        if (st == ST_IDLE) rd(ADDR_STATUS, ST_IDLE);
        if (st == ST_DATA_ACK || st == ST_DATA_NACK) begin
            rd(ADDR_DATA, b);
        end
    endtask : xfer
    task automatic frame(input logic [7:0] b, input logic ea,
        input logic [7:0] st);
        mst_u.bus_start();
        xfer(b, ea, st, 1'b1);
        mst_u.bus_stop();
    endtask : frame
    task automatic final_report;
        $display("num_errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // ****************
    // main sequence
    // ****************
    initial begin
        {reset_n, reg_write, reg_read, arb_lost, deep_sleep} = 5'h00;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        void'($urandom(32'h82FE));
        own = 7'h10 + 7'($urandom % 96);
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        rd(ADDR_SLAVE_MATCH, SLAVE_MATCH_RESET);
        rd(ADDR_STATUS, ST_IDLE);
        rd(3'h7, 8'h00);
        wr(ADDR_CONTROL, ctl(1'b1, 1'b0));
        rd(ADDR_CONTROL, ctl(1'b1, 1'b0));
        for (int g = 0; g < 2; g++) begin
            wr(ADDR_SLAVE_MATCH, {own, g[0]});
            rd(ADDR_SLAVE_MATCH, {own, g[0]});
            // acked byte, then ack enable dropped for the next one
            mst_u.bus_start();
            xfer({own, 1'b0}, 1'b1, ST_OWN_W, 1'b1);
            xfer(8'($urandom), 1'b1, ST_DATA_ACK, 1'b0);
            xfer(8'($urandom), 1'b0, ST_DATA_NACK, 1'b1);
            mst_u.bus_stop();
            rd(ADDR_STATUS, ST_IDLE);
            frame({own ^ 7'h01, 1'b0}, 1'b0, ST_IDLE);
            frame({own, 1'b1}, 1'b0, ST_IDLE);
            frame(8'h00, g[0], g ? ST_GCALL : ST_IDLE);
            wr(ADDR_CONTROL, ctl(1'b0, 1'b0));
            frame({own, 1'b0}, 1'b0, ST_IDLE);
            wr(ADDR_CONTROL, ctl(1'b1, 1'b0));
            frame({own, 1'b0}, 1'b1, ST_OWN_W);
            @(posedge clk);
            arb_lost <= 1'b1;
            @(posedge clk);
            arb_lost <= 1'b0;
            frame({own, 1'b0}, 1'b1, ST_ARB_OWN_W);
            if (g == 1) begin
                @(posedge clk);
                arb_lost <= 1'b1;
                @(posedge clk);
                arb_lost <= 1'b0;
                frame(8'h00, 1'b1, ST_ARB_GCALL);
            end
            @(posedge clk);
            deep_sleep <= 1'b1;
            rd(ADDR_SLEEP, 8'h01);
            frame({own, 1'b0}, 1'b1, ST_OWN_W);
            @(posedge clk);
            deep_sleep <= 1'b0;
        end
        final_report();
    end
endmodule : bus_status_code_slave_rx_test
`default_nettype wire
